// [rtl/stc_regs.vh]
// Purpose: register map, field positions and reset values of the 16-bit timer/counter
// Assumes: Avalon-MM slave with 32-bit data, one aligned word per register
// Notes:   byte addresses; narrower registers sit in the low bits
`ifndef STC_REGS_VH
`define STC_REGS_VH
`define STC_ADDR_W        4
`define STC_OFF_CONTROL   4'h0
`define STC_OFF_COUNT_LO  4'h4
`define STC_OFF_COUNT_HI  4'h8
`define STC_OFF_FLAGS     4'hC
`define STC_BIT_RUN       0
`define STC_BIT_SRC       1
`define STC_BIT_SYNC_BYP  2
`define STC_BIT_OSC_EN    3
`define STC_BIT_DIV_LO    4
`define STC_BIT_DIV_HI    5
`define STC_BIT_SYSCLK    6
`define STC_BIT_WIDE      7
`define STC_BIT_OVF_FLAG  0
`define STC_BIT_OVF_IE    1
`define STC_CTRL_RESET    8'h00
`define STC_CTRL_WMASK    8'hBF
`define STC_BYTE_ZERO     8'h00
`define STC_COUNT_MAX     16'hFFFF
`define STC_COUNT_ZERO    16'h0000
`define STC_WORD_ZERO     32'h0000_0000
`define STC_TRIG_CODE     4'hB
`define STC_QUARTER       2'h3
`endif

// [rtl/stc_sync2.v]
// Purpose: two flip-flop synchroniser for one level input
// Assumes: async input, destination clock core_clk_i
// Notes:   first stage is read only by the second stage
`timescale 1ns/100ps
`default_nettype none
module stc_sync2 (
  input  wire core_clk_i,
  input  wire resetn_i,
  input  wire async_i,
  output wire sync_o
);
  reg meta_q;
  reg sync_q;
  // two stage capture
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end
  assign sync_o = sync_q;
endmodule
`default_nettype wire

// [rtl/stc_divider.v]
// Purpose: count-source input divider, 1:1 to 1:8
// Assumes: tick_i is a one-cycle pulse per source edge
// Notes:   clear_i restarts the divider count
`timescale 1ns/100ps
`default_nettype none
module stc_divider #(
  parameter DIV_W = 3
) (
  input  wire       core_clk_i,
  input  wire       resetn_i,
  input  wire       tick_i,
  input  wire       clear_i,
  input  wire [1:0] select_i,
  output wire       tick_o
);
  reg  [DIV_W-1:0] cnt_q;
  wire [DIV_W-1:0] mask;
  // mask of divider bits used by each code
  assign mask = (select_i == 2'b00) ? 3'b000 :
                (select_i == 2'b01) ? 3'b001 :
                (select_i == 2'b10) ? 3'b011 : 3'b111;
  assign tick_o = tick_i && ((cnt_q & mask) == mask);
  // divider counter
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_q <= {DIV_W{1'b0}};
    end else if (clear_i) begin
      cnt_q <= {DIV_W{1'b0}};
    end else if (tick_i) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
endmodule
`default_nettype wire

// [rtl/stc_timer.v]
// Purpose: 16-bit timer/counter with source select, divider and wide access
// Assumes: core_clk_i is the system clock; the instruction clock is core_clk_i / 4
// Notes:   registers over Avalon-MM, one wait state on every access
//
// Our own choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none
`include "stc_regs.vh"
module stc_timer #(
  parameter CNT_W = 16
) (
  input  wire        core_clk_i,
  input  wire        resetn_i,
  input  wire [3:0]  avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  input  wire [3:0]  avs_byteenable_i,
  output reg  [31:0] avs_readdata_o,
  output reg         avs_waitrequest_o,
  input  wire        ext_count_pin_i,
  input  wire        lp_osc_clk_i,
  input  wire        sysclk_from_osc_i,
  input  wire        trigger_i,
  input  wire [3:0]  trigger_mode_i,
  output reg         osc_run_o,
  output reg         pins_force_input_o,
  output reg         overflow_irq_o
);
  ////////////////////////////////////////////////////////////////////////////
  // state
  reg  [7:0]       ctrl_q;
  reg  [CNT_W-1:0] count_q;
  reg  [7:0]       hi_buf_q;
  reg              ovf_flag_q;
  reg              ovf_ie_q;
  reg  [1:0]       phase_q;
  reg              ext_prev_q;
  reg              raw_prev_q;
  reg              raw_meta_q;
  reg              raw_q;
  wire             ext_sync;
  wire             osc_sync;
  wire             sysclk_sync;
  wire             div_tick;
  reg              src_tick;
  wire             bus_req;
  wire             acc_rd;
  wire             acc_wr;
  wire             wr_lo;
  wire             wr_hi;
  wire             rd_lo;
  wire             wr_ctrl;
  wire             wr_flags;
  wire             wide;
  wire             ext_level;
  wire             trig_hit;

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  stc_sync2 u_sync_ext (
    .core_clk_i (core_clk_i),
    .resetn_i   (resetn_i),
    .async_i    (ext_count_pin_i),
    .sync_o     (ext_sync)
  );
  stc_sync2 u_sync_osc (
    .core_clk_i (core_clk_i),
    .resetn_i   (resetn_i),
    .async_i    (lp_osc_clk_i),
    .sync_o     (osc_sync)
  );
  stc_sync2 u_sync_sys (
    .core_clk_i (core_clk_i),
    .resetn_i   (resetn_i),
    .async_i    (sysclk_from_osc_i),
    .sync_o     (sysclk_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus decode: one wait state, answer on second cycle of a request

  // address match shared by the write decodes and the low-byte read decode
  function addr_hit;
    input [3:0] addr;
    input [3:0] offs;
    begin
      addr_hit = (addr == offs);
    end
  endfunction

  assign bus_req  = (avs_read_i || avs_write_i) && avs_waitrequest_o;
  // read seen: read data and the high-byte snapshot are taken on one edge,
  // so a carry between the two bytes cannot tear a wide read
  assign acc_rd   = avs_read_i && bus_req;
  assign acc_wr   = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
  assign wide     = ctrl_q[`STC_BIT_WIDE];
  assign wr_lo    = acc_wr && addr_hit(avs_address_i, `STC_OFF_COUNT_LO);
  assign wr_hi    = acc_wr && addr_hit(avs_address_i, `STC_OFF_COUNT_HI);
  assign wr_ctrl  = acc_wr && addr_hit(avs_address_i, `STC_OFF_CONTROL);
  assign wr_flags = acc_wr && addr_hit(avs_address_i, `STC_OFF_FLAGS);
  assign rd_lo    = acc_rd && addr_hit(avs_address_i, `STC_OFF_COUNT_LO);

  // waitrequest high while idle, drops for one cycle to complete
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= !bus_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // count source selection
  // bypass path: selected source after its two-stage sync, never the raw pin,
  // so no logic reads a level that may still be metastable
  assign ext_level = ctrl_q[`STC_BIT_OSC_EN] ? osc_sync : ext_sync;

  // raw edge path still passes two flops before any logic reads it
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      raw_meta_q <= 1'b0;
      raw_q      <= 1'b0;
      raw_prev_q <= 1'b0;
      ext_prev_q <= 1'b0;
      phase_q    <= 2'b00;
    end else begin
      raw_meta_q <= ext_level;
      raw_q      <= raw_meta_q;
      raw_prev_q <= raw_q;
      ext_prev_q <= ctrl_q[`STC_BIT_OSC_EN] ? osc_sync : ext_sync;
      phase_q    <= phase_q + 2'b01;
    end
  end

  // tick generation per source and sync mode
  always @* begin
    src_tick = 1'b0;
    if (!ctrl_q[`STC_BIT_SRC]) begin
      src_tick = (phase_q == `STC_QUARTER);
    end else if (ctrl_q[`STC_BIT_SYNC_BYP]) begin
      src_tick = raw_q && !raw_prev_q;
    end else begin
      src_tick = (ctrl_q[`STC_BIT_OSC_EN] ? osc_sync : ext_sync) && !ext_prev_q;
    end
  end

  stc_divider #(
    .DIV_W (3)
  ) u_div (
    .core_clk_i (core_clk_i),
    .resetn_i   (resetn_i),
    .tick_i     (src_tick && ctrl_q[`STC_BIT_RUN]),
    .clear_i    (wr_lo),
    .select_i   (ctrl_q[`STC_BIT_DIV_HI:`STC_BIT_DIV_LO]),
    .tick_o     (div_tick)
  );

  assign trig_hit = trigger_i && (trigger_mode_i == `STC_TRIG_CODE) &&
                    !(ctrl_q[`STC_BIT_SRC] && ctrl_q[`STC_BIT_SYNC_BYP]);

  ////////////////////////////////////////////////////////////////////////////
  // counter, buffer and control registers
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_q     <= `STC_CTRL_RESET;
      count_q    <= `STC_COUNT_ZERO;
      hi_buf_q   <= `STC_BYTE_ZERO;
      ovf_flag_q <= 1'b0;
      ovf_ie_q   <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= avs_writedata_i[7:0] & `STC_CTRL_WMASK;
      end
      if (rd_lo && wide) begin
        hi_buf_q <= count_q[15:8];
      end
      if (wr_hi && wide) begin
        hi_buf_q <= avs_writedata_i[7:0];
      end
      if (wr_lo) begin
        count_q[7:0] <= avs_writedata_i[7:0];
        if (wide) begin
          count_q[15:8] <= hi_buf_q;
        end
      end else if (wr_hi && !wide) begin
        count_q[15:8] <= avs_writedata_i[7:0];
      end else if (trig_hit) begin
        count_q <= `STC_COUNT_ZERO;
      end else if (div_tick) begin
        count_q <= count_q + 1'b1;
      end
      // overflow flag, set wins over clear
      if (div_tick && !wr_lo && !(wr_hi && !wide) && !trig_hit &&
          count_q == `STC_COUNT_MAX) begin
        ovf_flag_q <= 1'b1;
      end else if (wr_flags) begin
        ovf_flag_q <= avs_writedata_i[`STC_BIT_OVF_FLAG];
      end
      if (wr_flags) begin
        ovf_ie_q <= avs_writedata_i[`STC_BIT_OVF_IE];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data mux and registered outputs
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      avs_readdata_o     <= `STC_WORD_ZERO;
      osc_run_o          <= 1'b0;
      pins_force_input_o <= 1'b0;
      overflow_irq_o     <= 1'b0;
    end else begin
      if (acc_rd) begin
        case (avs_address_i)
          `STC_OFF_CONTROL:  avs_readdata_o <= {24'h00_0000, ctrl_q[7],
                                               sysclk_sync, ctrl_q[5:0]};
          `STC_OFF_COUNT_LO: avs_readdata_o <= {24'h00_0000, count_q[7:0]};
          `STC_OFF_COUNT_HI: avs_readdata_o <= {24'h00_0000,
                                               (wide ? hi_buf_q : count_q[15:8])};
          `STC_OFF_FLAGS:    avs_readdata_o <= {30'h0000_0000, ovf_ie_q, ovf_flag_q};
          default:           avs_readdata_o <= `STC_WORD_ZERO;
        endcase
      end
      osc_run_o          <= ctrl_q[`STC_BIT_OSC_EN];
      pins_force_input_o <= ctrl_q[`STC_BIT_RUN];
      overflow_irq_o     <= ovf_flag_q && ovf_ie_q;
    end
  end
endmodule
`default_nettype wire

// [verification/stc_checker.sv]
// Purpose: port-level checks of the timer/counter
// Assumes: one clock, async active-low reset
// Notes:   shadows control and irq enable from completed writes
`timescale 1ns/100ps
`default_nettype none
module stc_checker (
  input wire        core_clk_i,
  input wire        resetn_i,
  input wire [3:0]  avs_address_i,
  input wire        avs_read_i,
  input wire        avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0]  avs_byteenable_i,
  input wire [31:0] avs_readdata_o,
  input wire        avs_waitrequest_o,
  input wire        sysclk_from_osc_i,
  input wire        osc_run_o,
  input wire        pins_force_input_o,
  input wire        overflow_irq_o
);
  logic [7:0] ctrl_q;
  logic       ie_q;
  wire        done = !avs_waitrequest_o;
  wire        wr0  = done && avs_write_i && avs_byteenable_i[0];
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  // shadow of writable control bits and irq enable
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_q <= 8'h00;
      ie_q   <= 1'b0;
    end else if (wr0 && avs_address_i == 4'h0) begin
      ctrl_q <= avs_writedata_i[7:0] & 8'hBF;
    end else if (wr0 && avs_address_i == 4'hC) begin
      ie_q <= avs_writedata_i[1];
    end
  end
  AST_ANSWER: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o |-> ##[1:2] !avs_waitrequest_o)
    else $error("access not answered in time");
  AST_ONE_LOW: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  AST_NO_SPUR: assert property (!avs_waitrequest_o |-> $past(avs_read_i || avs_write_i))
    else $error("answer without request");
  AST_CTRL_RD: assert property (
    done && avs_read_i && avs_address_i == 4'h0 |-> (avs_readdata_o[7:0] & 8'hBF) == ctrl_q)
    else $error("control readback wrong");
  AST_STATUS: assert property (
    done && avs_read_i && avs_address_i == 4'h0 && $stable(sysclk_from_osc_i)
    && sysclk_from_osc_i == $past(sysclk_from_osc_i, 4) |-> avs_readdata_o[6] == sysclk_from_osc_i)
    else $error("clock status bit wrong");
  AST_UNMAPPED: assert property (
    done && avs_read_i && avs_address_i[1:0] != 2'b00 |-> avs_readdata_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  AST_OSC: assert property (osc_run_o == $past(ctrl_q[3]))
    else $error("oscillator enable wrong");
  AST_PINS: assert property (
    ctrl_q[0] == $past(ctrl_q[0]) |-> pins_force_input_o == ctrl_q[0])
    else $error("pin forcing wrong");
  AST_IRQ_MASK: assert property (!ie_q && !$past(ie_q) |-> !overflow_irq_o)
    else $error("irq while masked");
endmodule
bind stc_timer stc_checker u_chk (
  .core_clk_i         (core_clk_i),
  .resetn_i           (resetn_i),
  .avs_address_i      (avs_address_i),
  .avs_read_i         (avs_read_i),
  .avs_write_i        (avs_write_i),
  .avs_writedata_i    (avs_writedata_i),
  .avs_byteenable_i   (avs_byteenable_i),
  .avs_readdata_o     (avs_readdata_o),
  .avs_waitrequest_o  (avs_waitrequest_o),
  .sysclk_from_osc_i  (sysclk_from_osc_i),
  .osc_run_o          (osc_run_o),
  .pins_force_input_o (pins_force_input_o),
  .overflow_irq_o     (overflow_irq_o)
);
`default_nettype wire

// [verification/stc_ext_src.sv]
// Purpose: external count pin and low-power oscillator
// Assumes: both free of the core clock
// Notes:   each wave stands still while disabled
`timescale 1ns/100ps
`default_nettype none
module stc_ext_src (
  input  wire  pin_en_i,
  input  wire  osc_run_i,
  output logic pin_o,
  output logic osc_o
);
  initial begin
    pin_o = 1'b0;
    forever #83 pin_o = pin_en_i ? !pin_o : pin_o;
  end
  initial begin
    osc_o = 1'b0;
    forever #37 osc_o = osc_run_i ? !osc_o : osc_o;
  end
endmodule
`default_nettype wire

// [verification/tb_top.sv]
// Purpose: self-checking bench of the timer/counter
// Assumes: one wait state per access
// Notes:   counts checked within a window
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  typedef struct {logic [7:0] lo; logic [7:0] hi; string nm;} stc_exp_t;
  logic core_clk_i, resetn_i, avs_read_i, avs_write_i, trigger_i, sysclk_i, pin_en;
  logic [3:0] avs_address_i, trigger_mode_i;
  logic [31:0] avs_writedata_i;
  wire [31:0] avs_readdata_o;
  wire avs_waitrequest_o, ext_pin, osc_clk, osc_run, pins_in, irq;
  stc_exp_t q[$];
  int n_fail = 0;
  int num_checks = 0;
  int seed = 67;
  logic [7:0] b;
  stc_timer u_dut (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .ext_count_pin_i(ext_pin), .lp_osc_clk_i(osc_clk),
    .sysclk_from_osc_i(sysclk_i), .trigger_i(trigger_i), .trigger_mode_i(trigger_mode_i),
    .osc_run_o(osc_run), .pins_force_input_o(pins_in), .overflow_irq_o(irq));
  stc_ext_src u_src (.pin_en_i(pin_en), .osc_run_i(osc_run), .pin_o(ext_pin), .osc_o(osc_clk));
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = !core_clk_i;
  end
  task automatic wrap_up();
    if (n_fail == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk_rd(input stc_exp_t e, input logic [7:0] seen);
    num_checks++;
    if ((seen >= e.lo && seen <= e.hi) !== 1'b1) begin
      n_fail++;
      $display("BAD %s exp %h..%h seen %h", e.nm, e.lo, e.hi, seen);
    end
  endtask
  task automatic chk_lvl(input logic e, input logic seen, input string nm);
    num_checks++;
    if (seen !== e) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, e, seen);
    end
  endtask
  // compare each read result with the oldest note
  always @(posedge core_clk_i)
    if (avs_read_i === 1'b1 && avs_waitrequest_o === 1'b0 && q.size() > 0)
      chk_rd(q.pop_front(), avs_readdata_o[7:0]);
  task automatic bus(input logic [3:0] a, input logic wr, input logic [7:0] d);
    int n;
    n = 0;
    avs_address_i <= a;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    avs_writedata_i <= {24'h00_0000, d};
    @(posedge core_clk_i);
    while (avs_waitrequest_o !== 1'b0 && n < 100) begin
      @(posedge core_clk_i);
      n++;
    end
    if (n >= 100)
      n_fail++;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge core_clk_i);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] lo, hi, input string nm);
    q.push_back('{lo, hi, nm});
    bus(a, 1'b0, 8'h00);
  endtask
  task automatic measure(input logic [7:0] c, input int cyc, input logic [7:0] lo, hi);
    bus(4'h8, 1'b1, 8'h00);
    bus(4'h4, 1'b1, 8'h00);
    bus(4'h0, 1'b1, c);
    repeat (cyc) @(posedge core_clk_i);
    chk_lvl(1'b1, pins_in, "pins run");
    bus(4'h0, 1'b1, c & 8'hFE);
    rd(4'h4, lo, hi, "count");
    chk_lvl(1'b0, pins_in, "pins idle");
  endtask
  task automatic trig(input logic [3:0] m, input logic clr);
    bus(4'h8, 1'b1, 8'h12);
    bus(4'h4, 1'b1, 8'h34);
    trigger_mode_i <= m;
    trigger_i <= 1'b1;
    @(posedge core_clk_i);
    trigger_i <= 1'b0;
    @(posedge core_clk_i);
    rd(4'h4, clr ? 8'h00 : 8'h34, clr ? 8'h00 : 8'h34, "trig lo");
  endtask
  initial begin
    #500000;
    n_fail++;
    wrap_up();
  end
  initial begin
    {resetn_i, avs_read_i, avs_write_i, trigger_i, sysclk_i, pin_en} = 6'b0;
    {avs_address_i, trigger_mode_i, avs_writedata_i} = '0;
    repeat (16) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    @(posedge core_clk_i);
    rd(4'h0, 8'h00, 8'h00, "ctrl reset");
    bus(4'h0, 1'b1, 8'hFF);
    rd(4'h0, 8'hBF, 8'hBF, "ctrl rw");
    bus(4'h0, 1'b1, 8'h00);
    sysclk_i <= 1'b1;
    repeat (6) @(posedge core_clk_i);
    rd(4'h0, 8'h40, 8'h40, "ctrl status");
    sysclk_i <= 1'b0;
    rd(4'h1, 8'h00, 8'h00, "unmapped");
    b = 8'($random(seed));
    bus(4'h8, 1'b1, b);
    bus(4'h4, 1'b1, ~b);
    repeat (20) @(posedge core_clk_i);
    rd(4'h4, ~b, ~b, "lo stopped");
    rd(4'h8, b, b, "hi direct");
    bus(4'h0, 1'b1, 8'h80);
    bus(4'h8, 1'b1, 8'h56);
    rd(4'h8, 8'h56, 8'h56, "hi buffer");
    bus(4'h0, 1'b1, 8'h00);
    rd(4'h8, b, b, "hi untouched");
    bus(4'h0, 1'b1, 8'h80);
    bus(4'h4, 1'b1, 8'h78);
    bus(4'h0, 1'b1, 8'h00);
    rd(4'h8, 8'h56, 8'h56, "hi moved");
    bus(4'h0, 1'b1, 8'h80);
    bus(4'h8, 1'b1, 8'hAA);
    rd(4'h4, 8'h78, 8'h78, "wide lo");
    rd(4'h8, 8'h56, 8'h56, "hi snapshot");
    bus(4'h0, 1'b1, 8'h00);
    bus(4'hC, 1'b1, 8'h02);
    bus(4'h8, 1'b1, 8'hFF);
    bus(4'h4, 1'b1, 8'hFC);
    bus(4'h0, 1'b1, 8'h01);
    repeat (40) @(posedge core_clk_i);
    bus(4'h0, 1'b1, 8'h00);
    rd(4'hC, 8'h03, 8'h03, "flags");
    rd(4'h8, 8'h00, 8'h00, "wrap hi");
    chk_lvl(1'b1, irq, "irq set");
    bus(4'hC, 1'b1, 8'h00);
    trig(4'hA, 1'b0);
    chk_lvl(1'b0, irq, "irq cleared");
    trig(4'hB, 1'b1);
    bus(4'h0, 1'b1, 8'h06);
    trig(4'hB, 1'b0);
    bus(4'h0, 1'b1, 8'h00);
    rd(4'hC, 8'h00, 8'h00, "trig flags");
    for (int d = 0; d < 4; d++)
      measure({2'b00, d[1:0], 4'h1}, 128 << d, 8'd30, 8'd35);
    pin_en <= 1'b1;
    measure(8'h13, 2000, 8'd45, 8'd51);
    measure(8'h07, 2000, 8'd93, 8'd99);
    pin_en <= 1'b0;
    bus(4'h0, 1'b1, 8'h08);
    repeat (50) @(posedge core_clk_i);
    measure(8'h0B, 1000, 8'd105, 8'd111);
    wrap_up();
  end
endmodule
`default_nettype wire
